/* verilog/ovw_window_regs.sv */
// Overlay window position registers, AXI4-Lite slave and scan window compare
`timescale 1ns/100ps
`include "ovw_cfg.svh"

module ovw_window_regs
    import ovw_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic frameStart,
    input wire logic scanValid,
    input wire logic [9:0] scanX,
    input wire logic [9:0] scanY,
    output logic overlayOn
);
    // ****************************************************************
    // Register storage
    // ****************************************************************
    logic [31:0] cfgR_r; // Config word, only used fields kept
    logic [31:0] hPos_r; // Horizontal bounds word
    logic [31:0] vPos_r; // Vertical bounds word
    logic [31:0] cfgAct_r; // Frame-latched copies used by the scan
    logic [31:0] hAct_r;
    logic [31:0] vAct_r;
    logic [15:0] widthPix_r; // Window width in pixels
    logic [10:0] heightLn_r; // Window height in lines
    logic overlaySel_r; // Overlay fetch select

    // ****************************************************************
    // AXI4-Lite write channel
    // ****************************************************************
    logic awGot_r; // Address captured
    logic wGot_r; // Data captured
    logic [`OVW_ADDR_W-1:0] wAddr_r;
    logic [31:0] wData_r;
    logic [3:0] wStrb_r;
    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic awUpperZero_r; // Upper address bits all zero
    wire awHs = s_axi_awvalid & awready_r;
    wire wHs = s_axi_wvalid & wready_r;
    wire doWrite = awGot_r & wGot_r & ~bvalid_r;
    wire bvalid_nxt = doWrite | (bvalid_r & ~s_axi_bready);
    wire awGot_nxt = (awGot_r | awHs) & ~doWrite;
    wire wGot_nxt = (wGot_r | wHs) & ~doWrite;
    wire awready_nxt = ~awGot_nxt & ~bvalid_nxt;
    wire wready_nxt = ~wGot_nxt & ~bvalid_nxt;

    // Byte lane mask, one lane per strobe bit
    logic [31:0] wMask;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            assign wMask[gi*8 +: 8] = {8{wStrb_r[gi]}};
        end
    endgenerate

    // Field masks keep unused bits at zero
    localparam logic [31:0] POS_MASK = 32'h03FF03FF;
    localparam logic [31:0] CFG_MASK = 32'h00080007 | 32'h00030000;
    wire wrCfg = doWrite & (wAddr_r == `OVW_OFF_CONFIG);
    wire wrHpos = doWrite & (wAddr_r == `OVW_OFF_HPOS);
    wire wrVpos = doWrite & (wAddr_r == `OVW_OFF_VPOS);
    wire wrStat = doWrite & (wAddr_r == `OVW_OFF_STATUS);
    wire wrHit = wrCfg | wrHpos | wrVpos | wrStat;
    wire [31:0] cfg_nxt = ((cfgR_r & ~wMask) | (wData_r & wMask)) & CFG_MASK;
    wire [31:0] hPos_nxt = ((hPos_r & ~wMask) | (wData_r & wMask)) & POS_MASK;
    wire [31:0] vPos_nxt = ((vPos_r & ~wMask) | (wData_r & wMask)) & POS_MASK;

    // Handshake flops; address and data may arrive in either order
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            awGot_r <= 1'b0;
            wGot_r <= 1'b0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
        end else begin
            awGot_r <= awGot_nxt;
            wGot_r <= wGot_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            bvalid_r <= bvalid_nxt;
        end
    end

    // Payload capture, no reset needed on data path
    always_ff @(posedge mclk) begin
        if (awHs) begin
            wAddr_r <= s_axi_awaddr[`OVW_ADDR_W-1:0];
        end
        if (wHs) begin
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
        end
        if (doWrite) begin
            // Upper address bits must be zero for a hit
            bresp_r <= (wrHit && awUpperZero_r) ? `OVW_RESP_OKAY : `OVW_RESP_SLVERR;
        end
    end

    // Upper address check held with the captured address
    always_ff @(posedge mclk) begin
        if (awHs) begin
            awUpperZero_r <= (s_axi_awaddr[31:`OVW_ADDR_W] == '0);
        end
    end

    // Register file; the status word is read-only, writes ignored
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cfgR_r <= `OVW_RST_WORD;
            hPos_r <= `OVW_RST_WORD;
            vPos_r <= `OVW_RST_WORD;
        end else if (awUpperZero_r) begin
            if (wrCfg) begin
                cfgR_r <= cfg_nxt;
            end
            if (wrHpos) begin
                hPos_r <= hPos_nxt;
            end
            if (wrVpos) begin
                vPos_r <= vPos_nxt;
            end
        end
    end

    // ****************************************************************
    // AXI4-Lite read channel
    // ****************************************************************
    logic arready_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    wire doRead = s_axi_arvalid & arready_r;
    wire rvalid_nxt = doRead | (rvalid_r & ~s_axi_rready);
    wire [`OVW_ADDR_W-1:0] rAddr = s_axi_araddr[`OVW_ADDR_W-1:0];
    wire rUpperZero = (s_axi_araddr[31:`OVW_ADDR_W] == '0);
    wire [31:0] statWord = {5'h00, heightLn_r, widthPix_r};
    // Read mux; unmapped addresses read zero with an error
    wire rHitCfg = rUpperZero & (rAddr == `OVW_OFF_CONFIG);
    wire rHitH = rUpperZero & (rAddr == `OVW_OFF_HPOS);
    wire rHitV = rUpperZero & (rAddr == `OVW_OFF_VPOS);
    wire rHitS = rUpperZero & (rAddr == `OVW_OFF_STATUS);
    wire rHit = rHitCfg | rHitH | rHitV | rHitS;
    wire [31:0] rMux = rHitCfg ? cfgR_r :
                       rHitH ? hPos_r :
                       rHitV ? vPos_r :
                       rHitS ? statWord : `OVW_RST_WORD;

    // Read handshake; one read in flight at a time
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= `OVW_RST_WORD;
            rresp_r <= `OVW_RESP_OKAY;
        end else begin
            arready_r <= ~rvalid_nxt;
            rvalid_r <= rvalid_nxt;
            if (doRead) begin
                rdata_r <= rMux;
                rresp_r <= rHit ? `OVW_RESP_OKAY : `OVW_RESP_SLVERR;
            end
        end
    end

    // ****************************************************************
    // Active copies and derived window size
    // ****************************************************************
    wire ovw_rot_t rotAct = ovw_rot_t'(cfgAct_r[`OVW_ROT_HI:`OVW_ROT_LO]);
    wire [2:0] bppAct = cfgAct_r[`OVW_BPP_HI:`OVW_BPP_LO];
    // Shift that divides by 32/bpp; codes above 16 bpp clamp
    wire [2:0] stepShift = (bppAct > 3'(OVW_BPP_16)) ? 3'h1 : (`OVW_LOG2_32 - bppAct);
    wire swapAxes = rotAct[0]; // 90 and 270 swap the axes
    wire [9:0] hStartF = hAct_r[`OVW_START_HI:`OVW_START_LO];
    wire [9:0] hEndF = hAct_r[`OVW_END_HI:`OVW_END_LO];
    wire [9:0] vStartF = vAct_r[`OVW_START_HI:`OVW_START_LO];
    wire [9:0] vEndF = vAct_r[`OVW_END_HI:`OVW_END_LO];
    // Span of each field pair, counted inclusive
    wire [10:0] hSpan = 11'(hEndF) - 11'(hStartF) + 11'h001;
    wire [10:0] vSpan = 11'(vEndF) - 11'(vStartF) + 11'h001;
    wire [10:0] colSpan = swapAxes ? vSpan : hSpan;
    wire [10:0] lineSpan = swapAxes ? hSpan : vSpan;
    wire [15:0] width_nxt = 16'(colSpan) << stepShift;

    // Bounds latch only at frame start so a scan is never torn
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cfgAct_r <= `OVW_RST_WORD;
            hAct_r <= `OVW_RST_WORD;
            vAct_r <= `OVW_RST_WORD;
            widthPix_r <= 16'h0000;
            heightLn_r <= 11'h000;
        end else begin
            if (frameStart) begin
                cfgAct_r <= cfgR_r;
                hAct_r <= hPos_r;
                vAct_r <= vPos_r;
            end
            widthPix_r <= width_nxt;
            heightLn_r <= lineSpan;
        end
    end

    // ****************************************************************
    // Scan compare
    // ****************************************************************
    // Pixel column to step units; lines are already one-line steps
    wire [9:0] stepX = scanX >> stepShift;
    // Unrotated: horizontal pair on columns, vertical pair on lines
    wire [9:0] colLo = swapAxes ? vStartF : hStartF;
    wire [9:0] colHi = swapAxes ? vEndF : hEndF;
    wire [9:0] lineLo = swapAxes ? hStartF : vStartF;
    wire [9:0] lineHi = swapAxes ? hEndF : vEndF;
    wire inCol = (stepX >= colLo) & (stepX <= colHi);
    wire inLine = (scanY >= lineLo) & (scanY <= lineHi);
    wire enAct = cfgAct_r[`OVW_EN_BIT];
    wire sel_nxt = scanValid & enAct & inCol & inLine;

    // Registered select keeps the output glitch free
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            overlaySel_r <= 1'b0;
        end else begin
            overlaySel_r <= sel_nxt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign overlayOn = overlaySel_r;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cbMain @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_vpos_unused: assert property (vPos_r[31:26] == 6'h00 && vPos_r[15:10] == 6'h00)
        else $error("Unused vertical bits not zero");
    a_vpos_reset: assert property ($past(rst_n) == 1'b0 |-> vPos_r == `OVW_RST_WORD)
        else $error("Vertical register not cleared by reset");
    a_hpos_write: assert property (wrHpos && awUpperZero_r && wStrb_r == 4'hF
        |=> hPos_r == ($past(wData_r) & POS_MASK))
        else $error("Horizontal word not stored");
    a_frame_hold: assert property (!frameStart |=> $stable(hAct_r) && $stable(vAct_r))
        else $error("Active bounds changed mid frame");
    a_sel_enable: assert property (overlaySel_r |-> $past(enAct))
        else $error("Overlay shown while disabled");
    a_sel_bounds: assert property (overlaySel_r |-> $past(scanY >= lineLo && scanY <= lineHi)
        && $past(stepX >= colLo && stepX <= colHi))
        else $error("Overlay outside its bounds");
    // Only meaningful when both pairs are ordered; reversed bounds select nothing
    a_step_swap: assert property (swapAxes && scanValid && enAct && scanY == hStartF
        && stepX == vStartF && hEndF >= hStartF && vEndF >= vStartF |=> overlaySel_r)
        else $error("Rotated start corner not selected");
    // The last reset edge clears the width flop, so the attempt must start out of reset
    a_width_size: assert property (rst_n && !swapAxes ##1 !swapAxes && $stable(hAct_r)
        && $stable(cfgAct_r) |-> widthPix_r == (16'($past(hSpan)) << $past(stepShift)))
        else $error("Width not derived from horizontal span");
    a_write_resp: assert property (doWrite |=> bvalid_r)
        else $error("Write response not raised");
    a_write_hold: assert property (bvalid_r && !s_axi_bready |=> bvalid_r && $stable(bresp_r))
        else $error("Write response dropped");
    a_read_hold: assert property (rvalid_r && !s_axi_rready |=> rvalid_r && $stable(rdata_r))
        else $error("Read answer dropped");
    a_read_resp: assert property (doRead |=> rvalid_r && rdata_r == $past(rMux))
        else $error("Read answer wrong or late");
endmodule

/* verilog/ovw_cfg.svh */
// Offsets, field positions, reset values and codes of the overlay window registers
`ifndef OVW_CFG_SVH
`define OVW_CFG_SVH
`define OVW_ADDR_W 8
`define OVW_OFF_CONFIG 8'h10
`define OVW_OFF_HPOS 8'h58
`define OVW_OFF_VPOS 8'h5C
`define OVW_OFF_STATUS 8'h60
`define OVW_RST_WORD 32'h00000000
`define OVW_FLD_W 10
`define OVW_END_HI 25
`define OVW_END_LO 16
`define OVW_START_HI 9
`define OVW_START_LO 0
`define OVW_EN_BIT 19
`define OVW_ROT_HI 17
`define OVW_ROT_LO 16
`define OVW_BPP_HI 2
`define OVW_BPP_LO 0
`define OVW_WID_HI 15
`define OVW_HGT_HI 26
`define OVW_HGT_LO 16
`define OVW_LOG2_32 3'h5
`define OVW_RESP_OKAY 2'h0
`define OVW_RESP_SLVERR 2'h2
`endif

/* verilog/ovw_pkg.sv */
// Types shared by the overlay window position logic
package ovw_pkg;
    // Rotation setting of the display pipeline
    typedef enum logic [1:0] {
        OVW_ROT_0 = 2'b00,
        OVW_ROT_90 = 2'b01,
        OVW_ROT_180 = 2'b10,
        OVW_ROT_270 = 2'b11
    } ovw_rot_t;
    // Colour depth code, value is log2 of bits per pixel
    typedef enum logic [2:0] {
        OVW_BPP_1 = 3'b000,
        OVW_BPP_2 = 3'b001,
        OVW_BPP_4 = 3'b010,
        OVW_BPP_8 = 3'b011,
        OVW_BPP_16 = 3'b100
    } ovw_bpp_t;
endpackage

/* test/ovw_scan_gen.sv */
// Panel scan source feeding positions and frame pulses to the overlay compare
`timescale 1ns/100ps
module ovw_scan_gen #(
    parameter int PanelW = 64,
    parameter int PanelH = 12
) (
    input wire logic mclk,
    input wire logic rst_n,
    output logic frameStart,
    output logic scanValid,
    output logic [9:0] scanX,
    output logic [9:0] scanY
);
    int x = 0; // Pixel in line, PanelW marks the line gap
    int y = 0; // Current line
    initial {frameStart, scanValid, scanX, scanY} = '0;
    // Lines of PanelW pixels, an idle cycle between lines, frame pulse alone
    always @(posedge mclk) begin
        frameStart <= 1'b0;
        scanValid <= 1'b0;
        // Idle cycles show the inverse so a stale position never looks valid
        scanX <= ~scanX;
        scanY <= ~scanY;
        if (!rst_n) begin
            x = PanelW;
            y = PanelH;
        end else if (x < PanelW) begin
            scanValid <= 1'b1;
            scanX <= 10'(x);
            scanY <= 10'(y);
            x++;
        end else if (y < PanelH - 1) begin
            y++;
            x = 0;
        end else begin
            frameStart <= 1'b1;
            x = 0;
            y = 0;
        end
    end
endmodule

/* test/ovw_window_regs_tb.sv */
// Self-checking bench for the overlay window position registers
`timescale 1ns/100ps
`include "ovw_cfg.svh"
module ovw_window_regs_tb;
    localparam logic [31:0] OffCfg = 32'(`OVW_OFF_CONFIG);
    localparam logic [31:0] OffH = 32'(`OVW_OFF_HPOS);
    localparam logic [31:0] OffV = 32'(`OVW_OFF_VPOS);
    localparam logic [31:0] OffSt = 32'(`OVW_OFF_STATUS);
    localparam logic [1:0] Ok = `OVW_RESP_OKAY;
    localparam logic [1:0] Err = `OVW_RESP_SLVERR;
    localparam int PanelW = 64; // Scan geometry shared with the partner
    localparam int PanelH = 12;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0;
    logic [3:0] wstrb = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, overlayOn;
    logic frameStart, scanValid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [9:0] scanX, scanY;
    int miscompares = 0;
    int checks = 0;
    // Software view of the registers, and the copy latched at frame start
    logic [31:0] mCfg = '0, mH = '0, mV = '0, aCfg = '0, aH = '0, aV = '0;
    logic expOn = 1'b0; // Expected overlay select for the last position
    always #5 mclk = ~mclk;
    ovw_window_regs dut_u (.mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .frameStart(frameStart), .scanValid(scanValid),
        .scanX(scanX), .scanY(scanY), .overlayOn(overlayOn));
    ovw_scan_gen #(.PanelW(PanelW), .PanelH(PanelH)) scan_u (.mclk(mclk), .rst_n(rst_n),
        .frameStart(frameStart), .scanValid(scanValid), .scanX(scanX), .scanY(scanY));
    // ********************
    // Checking and reporting
    // ********************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d, miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Overlay select: pixel axis counts steps of 32/bpp, rotation swaps axes
    function automatic logic onFn(input logic [31:0] c, h, v, input logic sv,
        input logic [9:0] sx, sy);
        int b, px, a, q;
        b = (c[2:0] > 3'h4) ? 4 : int'(c[2:0]);
        px = int'(sx) >> (5 - b);
        a = c[16] ? int'(sy) : px;
        q = c[16] ? px : int'(sy);
        return c[19] && sv && a >= int'(h[9:0]) && a <= int'(h[25:16])
            && q >= int'(v[9:0]) && q <= int'(v[25:16]);
    endfunction
    // Width in pixels and height in lines from the latched bounds
    function automatic logic [31:0] stFn(input logic [31:0] c, h, v);
        int b, w, t;
        logic [31:0] p, q;
        b = (c[2:0] > 3'h4) ? 4 : int'(c[2:0]);
        p = c[16] ? v : h;
        q = c[16] ? h : v;
        w = (int'(p[25:16]) - int'(p[9:0]) + 1) << (5 - b);
        t = int'(q[25:16]) - int'(q[9:0]) + 1;
        return {5'h00, t[10:0], w[15:0]};
    endfunction
    // Model follows the scan; bounds only change at a frame pulse
    always @(posedge mclk) begin
        if (!rst_n) begin
            expOn <= 1'b0;
            {aCfg, aH, aV} <= '0;
        end else begin
            expOn <= onFn(aCfg, aH, aV, scanValid, scanX, scanY);
            if (frameStart === 1'b1) begin
                {aCfg, aH, aV} <= {mCfg, mH, mV};
            end
        end
    end
    // Looked at mid-cycle, where the flop output has settled
    always @(negedge mclk) begin
        chk({31'h0, overlayOn}, {31'h0, expOn});
    end
    // ********************
    // AXI4-Lite master
    // ********************
    task automatic wr(input logic [31:0] a, d, input logic [3:0] s, input logic [1:0] er);
        logic aw, w;
        logic [31:0] m;
        aw = 1'b0;
        w = 1'b0;
        m = '0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        forever begin
            @(posedge mclk);
            if (!aw && awready === 1'b1) begin
                aw = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w && wready === 1'b1) begin
                w = 1'b1;
                wvalid <= 1'b0;
            end
            // Response taken only at an edge where both sides are high
            if (bvalid === 1'b1 && bready === 1'b1) begin
                chk({30'h0, bresp}, {30'h0, er});
                bready <= 1'b0;
                break;
            end
            // Late, random ready makes the slave hold its answer
            if (aw && w && $urandom % 2 == 0) begin
                bready <= 1'b1;
            end
        end
        // Strobed byte lanes only, unused bits never stored
        for (int i = 0; i < 4; i++) begin
            if (s[i]) m[8*i+:8] = 8'hFF;
        end
        if (a == OffCfg) mCfg = (mCfg & ~m) | (d & m & 32'h000B0007);
        if (a == OffH) mH = (mH & ~m) | (d & m & 32'h03FF03FF);
        if (a == OffV) mV = (mV & ~m) | (d & m & 32'h03FF03FF);
    endtask
    task automatic rd(input logic [31:0] a, ed, input logic [1:0] er);
        logic ar;
        ar = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        forever begin
            @(posedge mclk);
            if (!ar && arready === 1'b1) begin
                ar = 1'b1;
                arvalid <= 1'b0;
            end
            if (rvalid === 1'b1 && rready === 1'b1) begin
                chk(rdata, ed);
                chk({30'h0, rresp}, {30'h0, er});
                rready <= 1'b0;
                break;
            end
            if (ar && $urandom % 2 == 0) begin
                rready <= 1'b1;
            end
        end
    endtask
    // Software side: fields from window corners (x1, y1)-(x2, y2) at each rotation
    task automatic place(input int r, b);
        int st, xm, x1, x2, y1, y2, hs, he, vs, ve;
        st = 32 >> b; // Pixels per step
        xm = (r == 1) ? PanelH : PanelW; // At 90 x runs along the panel height
        x1 = $urandom % xm;
        x2 = x1 + $urandom % (xm - x1);
        // At 270 lines near the panel width keep the fields inside the scan
        y1 = ((r == 3) ? PanelW - PanelH : 0) + $urandom % PanelH;
        y2 = y1 + $urandom % (((r == 3) ? PanelW : PanelH) - y1);
        case (r)
            0: begin
                hs = x1 / st;
                he = x2 / st;
                vs = y1;
                ve = y2;
            end
            1: begin
                hs = y1;
                he = y2;
                vs = (PanelH - x2 - 1) / st;
                ve = (PanelH - x1 - 1) / st;
            end
            2: begin
                hs = (PanelW - x2 - 1) / st;
                he = (PanelW - x1 - 1) / st;
                vs = PanelH - y2 - 1;
                ve = PanelH - y1 - 1;
            end
            default: begin
                hs = PanelW - y2 - 1;
                he = PanelW - y1 - 1;
                vs = x1 / st;
                ve = x2 / st;
            end
        endcase
        wr(OffCfg, (32'h1 << `OVW_EN_BIT) | (32'(r) << `OVW_ROT_LO) | 32'(b), 4'hF, Ok);
        wr(OffH, {6'h00, 10'(he), 6'h00, 10'(hs)}, 4'hF, Ok);
        wr(OffV, {6'h00, 10'(ve), 6'h00, 10'(vs)}, 4'hF, Ok);
    endtask
    // ********************
    // Test sequence
    // ********************
    initial begin
        logic [31:0] cfg, hv, vv, s;
        void'($urandom(32'hBEE14829));
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        rd(OffCfg, 32'h0, Ok);
        rd(OffH, 32'h0, Ok);
        rd(OffV, 32'h0, Ok);
        rd(OffSt, stFn(aCfg, aH, aV), Ok);
        $display("test reset values done");
        rd(32'h00000020, 32'h0, Err);
        wr(32'h0000015C, 32'hFFFFFFFF, 4'hF, Err);
        wr(OffSt, 32'hFFFFFFFF, 4'hF, Ok);
        rd(OffSt, stFn(aCfg, aH, aV), Ok);
        wr(OffV, 32'hFFFFFFFF, 4'h1, Ok);
        rd(OffV, 32'h000000FF, Ok);
        $display("test refusals and lanes done");
        for (int k = 0; k < 10; k++) begin
            // Writes land mid-frame, clear of the next frame pulse
            @(posedge frameStart);
            @(posedge mclk);
            cfg = ($urandom & 32'hFFF4FFF8) | (32'(k != 8) << 19) | (32'(k % 4) << 16);
            cfg = cfg | ($urandom % 8);
            s = $urandom % 6;
            hv = ($urandom & 32'hFC00FC00) | s | ((s + $urandom % 6) << 16);
            s = $urandom % 6;
            vv = ($urandom & 32'hFC00FC00) | s | ((s + $urandom % 6) << 16);
            wr(OffCfg, cfg, 4'hF, Ok);
            wr(OffH, hv, 4'hF, Ok);
            wr(OffV, vv, 4'hF, Ok);
            rd(OffCfg, cfg & 32'h000B0007, Ok);
            rd(OffH, hv & 32'h03FF03FF, Ok);
            rd(OffV, vv & 32'h03FF03FF, Ok);
            @(posedge frameStart);
            repeat (2) @(posedge mclk);
            rd(OffSt, stFn(aCfg, aH, aV), Ok);
            $display("test window %0d done", k);
        end
        for (int k = 0; k < 8; k++) begin
            // Whole frames scanned with fields placed from panel coordinates
            @(posedge frameStart);
            @(posedge mclk);
            place(k % 4, $urandom % 5);
            repeat (2) @(posedge frameStart);
            repeat (2) @(posedge mclk);
            rd(OffSt, stFn(aCfg, aH, aV), Ok);
            $display("test rotation %0d done", k);
        end
        tally_and_finish();
    end
    // Cuts a hang short well past the expected run of some 34000 cycles
    initial begin
        #750000;
        miscompares++;
        tally_and_finish();
    end
endmodule
